// ==== src/atc_pkg.sv ====
// Purpose: Shared constants and types of the arc trip configuration logic
// Assumes: 125 MHz system clock
// Notes: Switch bit positions are zero based (switch n sits at bit n-1)
`default_nettype none
package atc_pkg;
    localparam int SW_BANK_W = 8;
    localparam int SENSOR_N = 15;
    localparam int TRIP_N = 4;
    // Protection bank field positions
    localparam int PB_SCHEME_LSB = 0;
    localparam int PB_SCHEME_W = 3;
    localparam int PB_RESERVED = 3;
    localparam int PB_BLOCK = 4;
    localparam int PB_LATCH = 5;
    localparam int PB_FIBRE_LOOP = 6;
    localparam int PB_LIGHT_ONLY = 7;
    // Field-bus bank field positions
    localparam int FB_ADDR_LSB = 0;
    localparam int FB_ADDR_W = 4;
    localparam int FB_STOP_ONE = 4;
    localparam int FB_PARITY_ODD = 5;
    localparam int FB_PARITY_EN = 6;
    localparam int FB_BAUD_SLOW = 7;
    localparam logic [7:0] FB_ADDR_BASE = 8'h14;
    localparam int FIBRE_CH = 4;
    localparam logic [2:0] SCHEME_MAIN = 3'h0;
    // Switch filter: stable time in microseconds and derived cycle count
    localparam int CLK_MHZ = 125;
    localparam int SW_STABLE_US = 1000;
    localparam int SW_STABLE_CYC = SW_STABLE_US * CLK_MHZ;
    // Quench test pulse period and width
    localparam int QTEST_PERIOD_US = 1000;
    localparam int QTEST_PERIOD_CYC = QTEST_PERIOD_US * CLK_MHZ;
    localparam int QTEST_WIDTH_US = 10;
    localparam int QTEST_WIDTH_CYC = QTEST_WIDTH_US * CLK_MHZ;
    localparam logic [SW_BANK_W-1:0] SW_RESET_VAL = 8'h00;

    typedef struct packed {
        logic [TRIP_N-1:0] trip;
        logic fast;
        logic light_signal;
        logic quench;
    } atc_outputs_type;

    typedef struct packed {
        logic [7:0] address;
        logic baud_slow;
        logic parity_en;
        logic parity_odd;
        logic stop_one;
    } atc_serial_cfg_type;
endpackage
`default_nettype wire

// ==== src/atc_switch_filter.sv ====
// Purpose: Debounce of a whole configuration switch bank
// Assumes: Bank already synchronised to clk_i
// Notes: The bank is taken as one word, so no mixed setting appears
`default_nettype none
module atc_switch_filter #(
    parameter int W = 8,
    parameter int STABLE_CYC = 125000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Bank in and filtered bank out
    input wire logic [W-1:0] bank_i,
    output logic [W-1:0] bank_o,
    output logic valid_o
);
    logic [W-1:0] last_reg;
    logic [31:0] cnt_reg;
    logic valid_reg;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            last_reg <= '0;
            cnt_reg <= '0;
        end else if (bank_i != last_reg) begin
            last_reg <= bank_i;
            cnt_reg <= '0;
        end else if (cnt_reg < 32'(STABLE_CYC)) begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            bank_o <= '0;
            valid_reg <= 1'b0;
        end else if (bank_i == last_reg && cnt_reg == 32'(STABLE_CYC)) begin
            bank_o <= last_reg;
            valid_reg <= 1'b1;
        end
    end

    assign valid_o = valid_reg;
endmodule
`default_nettype wire

// ==== src/atc_sync.sv ====
// Purpose: Three-stage synchroniser for an asynchronous input level
// Assumes: Input comes from a pin outside the clock domain
// Notes: A change counts once stages two and three agree
`default_nettype none
module atc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Level in and out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Per bit: hold old value while stages two and three disagree
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q_o <= '0;
        end else begin
            q_o <= (s2_reg & s3_reg) | (q_o & (s2_reg | s3_reg));
        end
    end
endmodule
`default_nettype wire

// ==== src/atc_trip_logic.sv ====
// Purpose: Switch decode and scheme 0 trip matrix of an arc protection unit
// Assumes: Light channels are detector levels, asynchronous to clk_i
// Notes: Schemes other than 0 drive no outputs but the test pulse; the field-bus engine
//        lives elsewhere and takes its settings from serial_cfg_o
`default_nettype none
// Operation
// R1: Scheme number from protection switches one to three
// R2: Switch 8 selects light only or light+overcurrent
// R3: Switch 7 selects loop sensor or quench control
// R4: Switch 6 latches trip relays and fast output
// R5: Switch 5 blocks all trip related outputs
// R6: Switch 4 reserved and ignored
// R7: Station address is 20 plus switches 1-4
// R8: Field-bus switch 8 picks 9600 or 19200 baud
// R9: Field-bus switch 7 enables parity bit
// R10: Field-bus switch 6 chooses odd or even parity
// R11: Field-bus switch 5 chooses one or two stops
// R12: Binary input one is overcurrent
// R13: Binary input two is external light
// R14: Light signal output from sensors only
// R15: Quench control needs light and overcurrent together
// R16: Trips qualified by light-only mode or overcurrent
// R17: Scheme 0 sensor light drives every output
// R18: Scheme 0 external light skips light signal output
// R19: Field-bus bank present only on field-bus variant
// R20: Switch banks synchronised and filtered
// R21: Latched outputs held until explicit reset request; here also cleared with switch 6 off or outside scheme 0
module atc_trip_logic #(
    parameter bit FIELDBUS_VARIANT = 1'b1,
    parameter int SW_STABLE_CYC = atc_pkg::SW_STABLE_CYC,
    parameter int QTEST_PERIOD_CYC = atc_pkg::QTEST_PERIOD_CYC,
    parameter int QTEST_WIDTH_CYC = atc_pkg::QTEST_WIDTH_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Configuration switch banks (on = 1)
    input wire logic [atc_pkg::SW_BANK_W-1:0] protection_switch_bank_i,
    input wire logic [atc_pkg::SW_BANK_W-1:0] fieldbus_switch_bank_i,
    // Detector inputs
    input wire logic [atc_pkg::SENSOR_N-1:0] sensor_channels_i,
    input wire logic overcurrent_in_i,
    input wire logic external_light_in_i,
    // Latch release request
    input wire logic latch_reset_i,
    // Protection outputs
    output logic [atc_pkg::TRIP_N-1:0] trip_relay_outputs_o,
    output logic fast_output_o,
    output logic light_signal_out_o,
    output logic quench_control_out_o,
    output logic fibre_five_test_pulse_o,
    // Decoded configuration
    output logic [atc_pkg::PB_SCHEME_W-1:0] scheme_o,
    output atc_pkg::atc_serial_cfg_type serial_cfg_o,
    output logic config_valid_o
);
    logic [atc_pkg::SW_BANK_W-1:0] pb_sync;
    logic [atc_pkg::SW_BANK_W-1:0] fb_sync;
    logic [atc_pkg::SW_BANK_W-1:0] fb_raw;
    logic [atc_pkg::SW_BANK_W-1:0] pb_cfg;
    logic [atc_pkg::SW_BANK_W-1:0] fb_cfg;
    logic [atc_pkg::SENSOR_N-1:0] sensors;
    logic overcurrent;
    logic ext_light;
    logic latch_reset;
    logic pb_valid;
    logic fb_valid;

    logic light_only;
    logic fibre_loop;
    logic latch_en;
    logic blocked;
    logic [atc_pkg::SENSOR_N-1:0] sensor_mask;
    logic sensor_light;
    logic any_light;
    logic qualified;
    logic scheme_main;
    atc_pkg::atc_outputs_type want;
    atc_pkg::atc_outputs_type out_reg;
    logic [atc_pkg::TRIP_N-1:0] trip_latch_reg;
    logic fast_latch_reg;
    logic [31:0] qtest_cnt_reg;
    logic qtest_reg;

    // Pin inputs all pass a three-stage synchroniser
    atc_sync #(
        .W(atc_pkg::SW_BANK_W)
    ) u_pb_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(protection_switch_bank_i),
        .q_o(pb_sync)
    ); // see R20

    // Basic variant has no second bank: its pins are not looked at
    assign fb_raw = FIELDBUS_VARIANT ? fieldbus_switch_bank_i
                                     : atc_pkg::SW_RESET_VAL; // see R19

    atc_sync #(
        .W(atc_pkg::SW_BANK_W)
    ) u_fb_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(fb_raw),
        .q_o(fb_sync)
    );

    atc_sync #(
        .W(atc_pkg::SENSOR_N + 3)
    ) u_in_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i({sensor_channels_i, overcurrent_in_i, external_light_in_i,
              latch_reset_i}),
        .q_o({sensors, overcurrent, ext_light, latch_reset})
    ); // see R12 see R13

    // Whole-bank debounce avoids passing through a wrong scheme
    atc_switch_filter #(
        .W(atc_pkg::SW_BANK_W),
        .STABLE_CYC(SW_STABLE_CYC)
    ) u_pb_filt (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .bank_i(pb_sync),
        .bank_o(pb_cfg),
        .valid_o(pb_valid)
    ); // see R20

    atc_switch_filter #(
        .W(atc_pkg::SW_BANK_W),
        .STABLE_CYC(SW_STABLE_CYC)
    ) u_fb_filt (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .bank_i(fb_sync),
        .bank_o(fb_cfg),
        .valid_o(fb_valid)
    ); // see R20

    assign config_valid_o = pb_valid & fb_valid;

    // Protection bank decode; bit PB_RESERVED is never read
    assign scheme_o = // see R1 see R6
        pb_cfg[atc_pkg::PB_SCHEME_LSB +: atc_pkg::PB_SCHEME_W];
    assign light_only = pb_cfg[atc_pkg::PB_LIGHT_ONLY]; // see R2
    assign fibre_loop = pb_cfg[atc_pkg::PB_FIBRE_LOOP]; // see R3
    assign latch_en = pb_cfg[atc_pkg::PB_LATCH]; // see R4
    assign blocked = pb_cfg[atc_pkg::PB_BLOCK]; // see R5
    assign scheme_main = (scheme_o == atc_pkg::SCHEME_MAIN) & pb_valid;

    // Field-bus decode registered: the engine never sees an adder settle
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            serial_cfg_o <= {atc_pkg::FB_ADDR_BASE, 4'h0};
        end else begin
            serial_cfg_o.address <= atc_pkg::FB_ADDR_BASE // see R7
                + 8'(fb_cfg[atc_pkg::FB_ADDR_LSB +: atc_pkg::FB_ADDR_W]);
            serial_cfg_o.baud_slow <= fb_cfg[atc_pkg::FB_BAUD_SLOW]; // see R8
            serial_cfg_o.parity_en <= fb_cfg[atc_pkg::FB_PARITY_EN]; // see R9
            serial_cfg_o.parity_odd <=
                fb_cfg[atc_pkg::FB_PARITY_ODD]; // see R10
            serial_cfg_o.stop_one <= fb_cfg[atc_pkg::FB_STOP_ONE]; // see R11
        end
    end

    // Fibre channel five is no light sensor in quench-control use
    always_comb begin
        sensor_mask = '1;
        sensor_mask[atc_pkg::FIBRE_CH] = fibre_loop; // see R3
    end

    assign sensor_light = |(sensors & sensor_mask);
    assign any_light = sensor_light | ext_light;
    assign qualified = light_only | overcurrent; // see R2 see R16

    // Scheme 0 matrix
    always_comb begin
        want.fast = scheme_main & any_light & qualified; // see R17 see R18
        want.trip = {atc_pkg::TRIP_N{want.fast}}; // see R17 see R18
        want.light_signal = scheme_main & sensor_light; // see R14 see R18
        want.quench = scheme_main & any_light & overcurrent
                      & ~fibre_loop; // see R15
    end

    // Latches set while enabled; cleared by request once idle, or when disabled or outside scheme 0
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            trip_latch_reg <= '0;
            fast_latch_reg <= 1'b0;
        end else if (!latch_en || !scheme_main) begin
            // Leaving scheme 0 drops held trips, so no stale relay stays shut
            trip_latch_reg <= '0;
            fast_latch_reg <= 1'b0;
        end else begin
            // Set wins over a release that meets a live condition
            trip_latch_reg <= want.trip // see R4 see R21
                | (trip_latch_reg & ~{atc_pkg::TRIP_N{latch_reset}});
            fast_latch_reg <= want.fast
                | (fast_latch_reg & ~latch_reset); // see R4 see R21
        end
    end

    // Output stage: blocking overrides, latches only keep state inside
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            out_reg <= '0;
        end else if (blocked) begin
            out_reg <= '0; // see R5
        end else begin
            out_reg.trip <= want.trip | trip_latch_reg; // see R4
            out_reg.fast <= want.fast | fast_latch_reg; // see R4
            out_reg.light_signal <= want.light_signal; // see R14
            out_reg.quench <= want.quench; // see R15
        end
    end

    // Periodic test pulse on the fibre five transmitter in quench use
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            qtest_cnt_reg <= '0;
            qtest_reg <= 1'b0;
        end else if ((fibre_loop || !pb_valid) && !qtest_reg) begin
            // A begun pulse runs to full width: a runt could be misread
            qtest_cnt_reg <= '0;
            qtest_reg <= 1'b0;
        end else begin
            if (qtest_cnt_reg >= 32'(QTEST_PERIOD_CYC - 1)) begin
                qtest_cnt_reg <= '0;
            end else begin
                qtest_cnt_reg <= qtest_cnt_reg + 32'h1;
            end
            qtest_reg <= qtest_cnt_reg < 32'(QTEST_WIDTH_CYC); // see R3
        end
    end

    assign trip_relay_outputs_o = out_reg.trip;
    assign fast_output_o = out_reg.fast;
    assign light_signal_out_o = out_reg.light_signal;
    assign quench_control_out_o = out_reg.quench;
    assign fibre_five_test_pulse_o = qtest_reg;
endmodule
`default_nettype wire

// ==== verif/atc_ext_devices.sv ====
// Purpose: Neighbour devices giving overcurrent and external light levels
// Assumes: Commands change at the falling edge
// Notes: One cycle of delay, as a real wire from another unit has some
`default_nettype none
module atc_ext_devices (
    input wire logic clk_i,
    input wire logic oc_cmd_i,
    input wire logic light_cmd_i,
    output logic overcurrent_in_o,
    output logic external_light_in_o
);
    initial begin
        overcurrent_in_o = 1'b0;
        external_light_in_o = 1'b0;
    end
    always @(negedge clk_i) begin
        overcurrent_in_o <= oc_cmd_i;
        external_light_in_o <= light_cmd_i;
    end
endmodule
`default_nettype wire

// ==== verif/atc_trip_logic_tb.sv ====
// Purpose: Self-checking bench of the arc trip configuration logic
// Assumes: Short filter and pulse counts for simulation
// Notes: Fixed waits cover the filter and the output pipeline
`default_nettype none
module atc_trip_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, resetn_i = 1'b0, oc_cmd = 1'b0, lt_cmd = 1'b0;
    logic lrst = 1'b0, oc, xl, fast, lso, qco, tp, cv;
    logic [7:0] pb = 8'h00, fb = 8'h00;
    logic [14:0] sens = 15'h0;
    logic [3:0] trip;
    logic [2:0] scheme;
    atc_pkg::atc_serial_cfg_type scfg, scfg_basic;
    int fails = 0, comparisons = 0, cycles = 0;
    atc_ext_devices ext (.clk_i(clk_i), .oc_cmd_i(oc_cmd),
        .light_cmd_i(lt_cmd), .overcurrent_in_o(oc),
        .external_light_in_o(xl));
    atc_trip_logic #(.FIELDBUS_VARIANT(1'b1), .SW_STABLE_CYC(8),
        .QTEST_PERIOD_CYC(20), .QTEST_WIDTH_CYC(2)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .protection_switch_bank_i(pb),
        .fieldbus_switch_bank_i(fb), .sensor_channels_i(sens),
        .overcurrent_in_i(oc), .external_light_in_i(xl),
        .latch_reset_i(lrst), .trip_relay_outputs_o(trip),
        .fast_output_o(fast), .light_signal_out_o(lso),
        .quench_control_out_o(qco), .fibre_five_test_pulse_o(tp),
        .scheme_o(scheme), .serial_cfg_o(scfg), .config_valid_o(cv));
    // Basic variant sees the same pins but must ignore the second bank
    atc_trip_logic #(.FIELDBUS_VARIANT(1'b0), .SW_STABLE_CYC(8),
        .QTEST_PERIOD_CYC(20), .QTEST_WIDTH_CYC(2)) dut_basic (
        .clk_i(clk_i), .resetn_i(resetn_i), .protection_switch_bank_i(pb),
        .fieldbus_switch_bank_i(fb), .sensor_channels_i(sens),
        .overcurrent_in_i(oc), .external_light_in_i(xl),
        .latch_reset_i(lrst), .trip_relay_outputs_o(),
        .fast_output_o(), .light_signal_out_o(),
        .quench_control_out_o(), .fibre_five_test_pulse_o(),
        .scheme_o(), .serial_cfg_o(scfg_basic), .config_valid_o());
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic complete_run;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Filter needs 8 stable cycles plus synchroniser and decode
    task automatic set_cfg(input logic [7:0] p, input logic [7:0] f);
        pb <= p;
        fb <= f;
        step(30);
    endtask
    task automatic drive(input logic [14:0] s, input logic o, input logic l);
        sens <= s;
        oc_cmd <= o;
        lt_cmd <= l;
        step(10);
    endtask
    function automatic logic [6:0] outs();
        return {trip, fast, lso, qco};
    endfunction
    task automatic t_serial;
        logic [7:0] v [4] = '{8'h01, 8'h88, 8'h5f, 8'ha6};
        for (int i = 0; i < 4; i++) begin
            set_cfg(8'h00, v[i]);
            check(cv, 1'b1);
            check(scfg.address, 8'h14 + v[i][3:0]);
            check(scfg[3:0], v[i][7:4]);
            check(scfg_basic, {8'h14, 4'h0});
        end
    endtask
    task automatic t_scheme;
        logic [7:0] v [4] = '{8'h01, 8'h02, 8'h04, 8'h0e};
        for (int i = 0; i < 4; i++) begin
            set_cfg(v[i], 8'h00);
            check(scheme, v[i][2:0]);
            drive(15'h1, 1'b1, 1'b0);
            check(outs(), 7'h00);
            drive(15'h0, 1'b0, 1'b0);
        end
        // A glitch shorter than the filter must not reach the decode
        pb <= 8'h03;
        step(3);
        set_cfg(8'h0e, 8'h00);
        check(scheme, 3'h6);
    endtask
    task automatic t_matrix;
        logic [7:0] p [10] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h08,
            8'h08, 8'h90, 8'hc0, 8'h80, 8'hc0};
        logic [14:0] s [10] = '{15'h1, 15'h1, 15'h0, 15'h4000, 15'h4000,
            15'h0, 15'h1, 15'h10, 15'h10, 15'h1};
        logic [1:0] ox [10] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h3, 2'h3,
            2'h0, 2'h2, 2'h2};
        logic [6:0] e [10] = '{7'h7e, 7'h7f, 7'h7c, 7'h02, 7'h7f, 7'h7d,
            7'h00, 7'h7e, 7'h00, 7'h7e};
        for (int i = 0; i < 10; i++) begin
            set_cfg(p[i], 8'h00);
            drive(s[i], ox[i][1], ox[i][0]);
            check(outs(), e[i]);
            drive(15'h0, 1'b0, 1'b0);
            check(outs(), 7'h00);
        end
    endtask
    task automatic t_latch;
        set_cfg(8'ha0, 8'h00);
        drive(15'h1, 1'b0, 1'b0);
        drive(15'h0, 1'b0, 1'b0);
        check(outs(), 7'h7c);
        lrst <= 1'b1;
        drive(15'h1, 1'b0, 1'b0);
        check(outs(), 7'h7e);
        drive(15'h0, 1'b0, 1'b0);
        check(outs(), 7'h00);
        lrst <= 1'b0;
    endtask
    task automatic t_pulse(input logic [7:0] p, input int exp);
        int n;
        n = 0;
        set_cfg(p, 8'h00);
        repeat (40) begin
            @(negedge clk_i);
            n += int'(tp === 1'b1);
        end
        check(n[15:0], exp[15:0]);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        step(8);
        resetn_i <= 1'b1;
        check(cv, 1'b0);
        t_serial();
        t_scheme();
        t_matrix();
        t_latch();
        t_pulse(8'h80, 4);
        t_pulse(8'hc0, 0);
        complete_run();
    end
endmodule
`default_nettype wire

// ==== verif/atc_trip_sva.sv ====
// Purpose: Port checker for the arc trip configuration logic
// Assumes: Bound to atc_trip_logic, one clock domain
// Notes: Relations between outputs; pin to output latency is loose
`default_nettype none
module atc_trip_sva #(
    parameter int QTEST_WIDTH_CYC = 2
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [atc_pkg::TRIP_N-1:0] trip_relay_outputs_o,
    input wire logic fast_output_o,
    input wire logic light_signal_out_o,
    input wire logic quench_control_out_o,
    input wire logic fibre_five_test_pulse_o,
    input wire logic [atc_pkg::PB_SCHEME_W-1:0] scheme_o,
    input wire atc_pkg::atc_serial_cfg_type serial_cfg_o,
    input wire logic config_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic [15:0] hi_cnt;
    always_ff @(posedge clk_i) begin
        hi_cnt <= fibre_five_test_pulse_o ? hi_cnt + 16'h1 : 16'h0;
    end
    sequence s_quiet;
        trip_relay_outputs_o == 4'h0 && !fast_output_o &&
            !light_signal_out_o && !quench_control_out_o;
    endsequence
    sequence s_other_scheme;
        (scheme_o != 3'h0) [*4];
    endsequence
    a_reset_clears: assert property (disable iff (1'b0)
        !resetn_i |=> s_quiet ##0 !config_valid_o) else $error("no reset");
    a_valid_gates: assert property (!config_valid_o |-> s_quiet)
        else $error("output before valid");
    a_quench_trips: assert property (quench_control_out_o |->
        trip_relay_outputs_o == 4'hf && fast_output_o) else $error("quench");
    a_trip_group: assert property (fast_output_o ==
        trip_relay_outputs_o[0] && trip_relay_outputs_o inside {4'h0, 4'hf})
        else $error("trip group split");
    a_addr_range: assert property (config_valid_o |->
        serial_cfg_o.address inside {[8'h14:8'h23]}) else $error("address");
    a_scheme_off: assert property (s_other_scheme |=> s_quiet)
        else $error("scheme not zero drives outputs");
    a_pulse_width: assert property ($fell(fibre_five_test_pulse_o) |->
        hi_cnt == QTEST_WIDTH_CYC) else $error("test pulse width");
    a_pulse_gap: assert property ($fell(fibre_five_test_pulse_o) |->
        !fibre_five_test_pulse_o [*8]) else $error("test pulse gap");
endmodule
bind atc_trip_logic atc_trip_sva #(.QTEST_WIDTH_CYC(QTEST_WIDTH_CYC)) u_sva (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .trip_relay_outputs_o(trip_relay_outputs_o), .fast_output_o(fast_output_o),
    .light_signal_out_o(light_signal_out_o),
    .quench_control_out_o(quench_control_out_o),
    .fibre_five_test_pulse_o(fibre_five_test_pulse_o), .scheme_o(scheme_o),
    .serial_cfg_o(serial_cfg_o), .config_valid_o(config_valid_o));
`default_nettype wire
